// >>> core/cpu_state_consts.vh
// Contract
// - Status bit 7 gates every interrupt; clear blocks all, set defers to enables.
// - Taking an interrupt clears the gate; return-from-interrupt sets it again.
// - Gate-on and gate-off instructions set and clear the gate directly.
// - Bit 6 is scratch: bit-store copies a register bit in, bit-load copies out; code reads the register at addr instead when rd is high in that cycle.
// - Bit 5 records carry out of low nibble for operations defining it.
// - Bit 4 always equals negative flag XOR overflow flag.
// - Bit 3 flags two's complement overflow of arithmetic.
// - Bit 2 set when result most significant bit is one.
// - Bit 1 set when result is zero, cleared otherwise.
// - Bit 0 records carry of arithmetic or logic operation.
// - Status word updated after every ALU operation.
// - Status word not saved on interrupt entry nor restored on return.
// - Bank holds 32 eight-bit registers, each directly addressable.
// - Bank supports 8r/8w, two 8r/8w, two 8r/16w, 16r/16w arrangements.
// - Bank accesses complete in one clock cycle.
// - Each working register answers at data space addresses 0 to 31.
`ifndef CPU_STATE_CONSTS_VH
`define CPU_STATE_CONSTS_VH
`define SR_GATE_BIT     7
`define SR_SCRATCH_BIT  6
`define SR_HALF_BIT     5
`define SR_SIGN_BIT     4
`define SR_OVF_BIT      3
`define SR_NEG_BIT      2
`define SR_ZERO_BIT     1
`define SR_CARRY_BIT    0
`define SR_RESET_VAL    8'h00
`define STATUS_OFFSET   6'h3F
`define PTR_X_LOW       5'h1A
`define PTR_Y_LOW       5'h1C
`define PTR_Z_LOW       5'h1E
`define WREG_COUNT      32
`endif

// >>> core/cpu_state_regs.v
`timescale 1ns/100ps
`include "cpu_state_consts.vh"
// Status word and working register bank of the core
module cpu_state_regs (
  input  wire        clk,
  input  wire        srst,
  // Register operand ports
  input  wire [4:0]  src_a_addr,
  input  wire [4:0]  src_b_addr,
  output wire [7:0]  src_a_data,
  output wire [7:0]  src_b_data,
  output wire [15:0] src_pair_data,
  input  wire        res_we,
  input  wire        res_pair,
  input  wire [4:0]  res_addr,
  input  wire [15:0] res_data,
  // ALU flag update
  input  wire        alu_done,
  input  wire [7:0]  alu_result,
  input  wire        alu_carry,
  input  wire        alu_half,
  input  wire        alu_ovf,
  input  wire        alu_half_en,
  input  wire        alu_ovf_en,
  input  wire        alu_carry_en,
  // Bit copy instructions
  input  wire        store_to_scratch_bit,
  input  wire        load_from_scratch_bit,
  input  wire [2:0]  bit_sel,
  input  wire [4:0]  bit_reg,
  // Interrupt gate control
  input  wire        irq_gate_on,
  input  wire        irq_gate_off,
  input  wire        irq_taken,
  input  wire        return_from_irq,
  input  wire        irq_request,
  output wire        irq_accept,
  // Pointer registers
  output wire [15:0] ptr_x,
  output wire [15:0] ptr_y,
  output wire [15:0] ptr_z,
  // Software register port
  input  wire [5:0]  addr,
  input  wire [7:0]  wdata,
  input  wire        wr,
  input  wire        rd,
  output reg  [7:0]  rdata
);
  reg  [7:0]  status_reg;
  reg  [7:0]  status_next;
  reg         bank_we;
  reg         bank_pair;
  reg  [4:0]  bank_addr;
  reg  [15:0] bank_data;
  wire [7:0]  bit_reg_data;
  reg  [7:0]  rd_mux;

  // Insert one bit into a byte
  function [7:0] set_bit;
    input [7:0] val;
    input [2:0] pos;
    input       b;
    begin
      set_bit      = val;
      set_bit[pos] = b;
    end
  endfunction

  // Pointer reads via fixed taps of the shadow copy below
  wire [7:0] x_lo, x_hi, y_lo, y_hi, z_lo, z_hi;

  working_reg_bank #(.DEPTH(`WREG_COUNT)) u_bank (
    .clk        (clk),
    .srst       (srst),
    .rd_a_addr  (src_a_addr),
    .rd_b_addr  (src_b_addr),
    .rd_c_addr  (rd ? addr[4:0] : bit_reg),
    .rd_a_data  (src_a_data),
    .rd_b_data  (src_b_data),
    .rd_c_data  (bit_reg_data),
    .rd_pair_hi (src_pair_data[15:8]),
    .wr_en      (bank_we),
    .wr_pair    (bank_pair),
    .wr_addr    (bank_addr),
    .wr_data    (bank_data)
  );
  // 16-bit operand is the port A byte below the odd byte of its aligned pair
  assign src_pair_data[7:0] = src_a_data;

  // Pointer taps come from a shadow copy of bank writes; a small copy avoids more ports
  reg [7:0] ptr_shadow [0:5];
  integer k;
  always @(posedge clk) begin
    if (srst) begin
      for (k = 0; k < 6; k = k + 1)
        ptr_shadow[k] <= 8'h00;
    end else if (bank_we && bank_addr >= `PTR_X_LOW) begin
      if (bank_pair) begin
        ptr_shadow[{bank_addr[2:1], 1'b0} - 3'd2] <= bank_data[7:0];
        ptr_shadow[{bank_addr[2:1], 1'b1} - 3'd2] <= bank_data[15:8];
      end else begin
        ptr_shadow[bank_addr[2:0] - 3'd2] <= bank_data[7:0];
      end
    end
  end
  assign x_lo = ptr_shadow[0];
  assign x_hi = ptr_shadow[1];
  assign y_lo = ptr_shadow[2];
  assign y_hi = ptr_shadow[3];
  assign z_lo = ptr_shadow[4];
  assign z_hi = ptr_shadow[5];
  assign ptr_x = {x_hi, x_lo};
  assign ptr_y = {y_hi, y_lo};
  assign ptr_z = {z_hi, z_lo};

  // Bank write source: software store wins, then bit-load, then result
  always @* begin
    bank_we   = 1'b0;
    bank_pair = 1'b0;
    bank_addr = res_addr;
    bank_data = res_data;
    if (wr && addr < 6'h20) begin
      bank_we   = 1'b1; // Data space 0..31 maps to bank
      bank_addr = addr[4:0];
      bank_data = {8'h00, wdata};
    end else if (load_from_scratch_bit) begin
      bank_we   = 1'b1;
      bank_addr = bit_reg;
      bank_data = {8'h00, set_bit(bit_reg_data, bit_sel, status_reg[`SR_SCRATCH_BIT])};
    end else if (res_we) begin
      bank_we   = 1'b1;
      bank_pair = res_pair;
    end
  end

  // Gate masks every request; individual enables sit upstream
  assign irq_accept = irq_request & status_reg[`SR_GATE_BIT];

  // Status next value; nothing here saves or restores on interrupts
  always @* begin
    status_next = status_reg;
    if (alu_done) begin
      status_next[`SR_NEG_BIT]  = alu_result[7];
      status_next[`SR_ZERO_BIT] = (alu_result == 8'h00);
      if (alu_carry_en)
        status_next[`SR_CARRY_BIT] = alu_carry;
      if (alu_half_en)
        status_next[`SR_HALF_BIT] = alu_half;
      if (alu_ovf_en)
        status_next[`SR_OVF_BIT] = alu_ovf;
      status_next[`SR_SIGN_BIT] = status_next[`SR_NEG_BIT]
                                ^ status_next[`SR_OVF_BIT];
    end
    if (store_to_scratch_bit)
      status_next[`SR_SCRATCH_BIT] = bit_reg_data[bit_sel];
    if (irq_gate_off)
      status_next[`SR_GATE_BIT] = 1'b0;
    if (irq_gate_on)
      status_next[`SR_GATE_BIT] = 1'b1;
    if (return_from_irq)
      status_next[`SR_GATE_BIT] = 1'b1;
    if (irq_taken)
      status_next[`SR_GATE_BIT] = 1'b0;
    // Software write overrides all bits in that cycle
    if (wr && addr == `STATUS_OFFSET)
      status_next = {wdata[7:5],
                     wdata[`SR_NEG_BIT] ^ wdata[`SR_OVF_BIT],
                     wdata[3:0]};
  end

  always @(posedge clk) begin
    if (srst)
      status_reg <= `SR_RESET_VAL;
    else
      status_reg <= status_next;
  end

  // Read data one cycle after the strobe; unmapped reads zero
  always @* begin
    if (addr < 6'h20)
      rd_mux = bit_reg_data;
    else if (addr == `STATUS_OFFSET)
      rd_mux = status_reg;
    else
      rd_mux = 8'h00;
  end

  always @(posedge clk) begin
    if (srst)
      rdata <= 8'h00;
    else if (rd)
      rdata <= rd_mux;
  end
endmodule // cpu_state_regs

// >>> core/working_reg_bank.v
`timescale 1ns/100ps
// 32 x 8 bank, three byte reads plus pair high byte, one byte or pair write per cycle
module working_reg_bank #(
  parameter DEPTH = 32
) (
  input  wire       clk,
  input  wire       srst,
  input  wire [4:0] rd_a_addr,
  input  wire [4:0] rd_b_addr,
  input  wire [4:0] rd_c_addr,
  output wire [7:0] rd_a_data,
  output wire [7:0] rd_b_data,
  output wire [7:0] rd_c_data,
  output wire [7:0] rd_pair_hi,
  input  wire       wr_en,
  input  wire       wr_pair,
  input  wire [4:0] wr_addr,
  input  wire [15:0] wr_data
);
  reg [7:0] mem [0:DEPTH-1];
  integer i;
  // Reads are combinational so an instruction finishes in one cycle
  assign rd_a_data  = mem[rd_a_addr];
  assign rd_b_data  = mem[rd_b_addr];
  assign rd_c_data  = mem[rd_c_addr];
  assign rd_pair_hi = mem[{rd_a_addr[4:1], 1'b1}];
  // Byte or aligned pair write, low byte at even index
  always @(posedge clk) begin
    if (srst) begin
      for (i = 0; i < DEPTH; i = i + 1)
        mem[i] <= 8'h00;
    end else if (wr_en) begin
      if (wr_pair) begin
        mem[{wr_addr[4:1], 1'b0}] <= wr_data[7:0];
        mem[{wr_addr[4:1], 1'b1}] <= wr_data[15:8];
      end else begin
        mem[wr_addr] <= wr_data[7:0];
      end
    end
  end
endmodule // working_reg_bank

// >>> sim/alu_model.sv
`timescale 1ns/100ps
// Decoder side adder and subtractor that produces the flag inputs
module alu_model (
  input  wire [7:0] a,
  input  wire [7:0] b,
  input  wire       sub,
  output wire [7:0] alu_result,
  output wire       alu_carry,
  output wire       alu_half,
  output wire       alu_ovf
);
  wire [8:0] sum = sub ? {1'b0, a} - {1'b0, b} : {1'b0, a} + {1'b0, b};
  // Borrow doubles as carry on subtract
  assign alu_result = sum[7:0];
  assign alu_carry  = sum[8];
  assign alu_half   = sub ? a[3:0] < b[3:0] : a[3:0] + b[3:0] > 5'h0F;
  assign alu_ovf    = (a[7] ^ b[7] ^ !sub) & (sum[7] ^ a[7]);
endmodule // alu_model

// >>> sim/cpu_state_checker.sv
`timescale 1ns/100ps
// Gate and data space relations seen at the ports
module cpu_state_checker (
  input wire       clk,
  input wire       srst,
  input wire       wr,
  input wire       rd,
  input wire [5:0] addr,
  input wire [7:0] wdata,
  input wire [7:0] rdata,
  input wire       alu_done,
  input wire [7:0] alu_result,
  input wire       res_we,
  input wire       load_from_scratch_bit,
  input wire       irq_gate_on,
  input wire       irq_gate_off,
  input wire       irq_taken,
  input wire       return_from_irq,
  input wire       irq_request,
  input wire       irq_accept
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // Status strobes and gate priority helpers
  wire sw = wr && addr == 6'h3F;
  wire sr = rd && addr == 6'h3F;
  wire hi = irq_taken || sw;
  sequence s_alu; alu_done && !wr ##1 !(alu_done || wr) ##1 sr; endsequence
  sequence s_wr; wr && !addr[5] ##1 !(wr || res_we || load_from_scratch_bit); endsequence
  property p_take; irq_taken && !sw |=> !irq_accept; endproperty
  a_take: assert property (p_take) else $error("gate open after entry");
  property p_on; irq_gate_on && !hi ##1 irq_request |-> irq_accept; endproperty
  a_on: assert property (p_on) else $error("gate shut after gate on");
  property p_off; irq_gate_off && !hi && !irq_gate_on && !return_from_irq |=> !irq_accept;
  endproperty
  a_off: assert property (p_off) else $error("gate open after gate off");
  property p_swg; sw ##1 irq_request |-> irq_accept == $past(wdata[7]); endproperty
  a_swg: assert property (p_swg) else $error("gate not written");
  property p_zn; s_alu |=> rdata[2:1] == {$past(alu_result[7], 3), $past(alu_result, 3) == 8'h00};
  endproperty
  a_zn: assert property (p_zn) else $error("zero or negative flag wrong");
  property p_sign; sr |=> rdata[4] == (rdata[2] ^ rdata[3]); endproperty
  a_sign: assert property (p_sign) else $error("sign flag wrong");
  property p_hole; rd && addr[5] && !sr |=> rdata == 8'h00; endproperty
  a_hole: assert property (p_hole) else $error("unmapped read not zero");
  property p_map; s_wr ##1 rd && addr == $past(addr, 2) |=> rdata == $past(wdata, 3); endproperty
  a_map: assert property (p_map) else $error("register readback wrong");
endmodule // cpu_state_checker
bind cpu_state_regs cpu_state_checker chk (.clk, .srst, .wr, .rd, .addr, .wdata, .rdata,
  .alu_done, .alu_result, .res_we, .load_from_scratch_bit, .irq_gate_on, .irq_gate_off,
  .irq_taken, .return_from_irq, .irq_request, .irq_accept);

// >>> sim/testbench.sv
`timescale 1ns/100ps
`include "cpu_state_consts.vh"
`define CHK(n, e, s) begin num_checks++; if ((e) !== (s)) begin mismatches++; \
  $display("mismatch %s exp %h got %h", n, e, s); end end
module testbench;
  logic        clk = 0, srst = 1, wr = 0, rd = 0, alu_done = 0, sub = 0, irq_request = 1;
  logic        res_we = 0, res_pair = 0, store_to_scratch_bit = 0, load_from_scratch_bit = 0;
  logic        alu_half_en = 0, alu_ovf_en = 0, alu_carry_en = 0, irq_taken = 0;
  logic        irq_gate_on = 0, irq_gate_off = 0, return_from_irq = 0;
  logic [2:0]  bit_sel = 0;
  logic [3:0]  gv [7] = '{4'h8, 4'h2, 4'h1, 4'h4, 4'h8, 4'h4, 4'h8};
  logic [4:0]  src_a_addr = 0, src_b_addr = 0, res_addr = 0, bit_reg = 0, r;
  logic [5:0]  addr = 0;
  logic [7:0]  a = 0, b = 0, wdata = 0, m [64];
  logic [15:0] res_data = 0;
  wire  [7:0]  src_a_data, src_b_data, rdata, alu_result;
  wire  [15:0] src_pair_data, ptr_x, ptr_y, ptr_z;
  wire         alu_carry, alu_half, alu_ovf, irq_accept;
  integer      seed = 32'h9A0DC2A0, mismatches = 0, num_checks = 0, cycles = 0, i;
  alu_model u_alu (.a, .b, .sub, .alu_result, .alu_carry, .alu_half, .alu_ovf);
  cpu_state_regs dut (.clk, .srst, .src_a_addr, .src_b_addr, .src_a_data, .src_b_data,
    .src_pair_data, .res_we, .res_pair, .res_addr, .res_data, .alu_done, .alu_result,
    .alu_carry, .alu_half, .alu_ovf, .alu_half_en, .alu_ovf_en, .alu_carry_en,
    .store_to_scratch_bit, .load_from_scratch_bit, .bit_sel, .bit_reg, .irq_gate_on,
    .irq_gate_off, .irq_taken, .return_from_irq, .irq_request, .irq_accept, .ptr_x,
    .ptr_y, .ptr_z, .addr, .wdata, .wr, .rd, .rdata);
  // Core clock
  initial forever #2 clk = ~clk;
  // Hang guard, run needs under a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      results();
    end
  end
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Unmapped writes leave the model alone; status write forces sign
  task automatic wreg(input [5:0] ad, input [7:0] d);
    @(posedge clk) {wr, addr, wdata} <= {1'b1, ad, d};
    @(posedge clk) wr <= 0;
    if (!ad[5]) m[ad] = d;
    if (ad == `STATUS_OFFSET) m[ad] = {d[7:5], d[2] ^ d[3], d[3:0]};
  endtask
  task automatic rreg(input [5:0] ad);
    @(posedge clk) {rd, addr} <= {1'b1, ad};
    @(posedge clk) rd <= 0;
    @(negedge clk) `CHK("rdata", m[ad], rdata)
  endtask
  task automatic resw(input p, input [4:0] ad, input [15:0] d);
    @(posedge clk) {res_we, res_pair, res_addr, res_data} <= {1'b1, p, ad, d};
    @(posedge clk) res_we <= 0;
    m[ad] = d[7:0];
    if (p) m[ad | 5'h01] = d[15:8];
  endtask
  task automatic bop(input s, input [4:0] rg, input [2:0] p);
    @(posedge clk) {store_to_scratch_bit, load_from_scratch_bit, bit_reg, bit_sel} <= {s, !s, rg, p};
    @(posedge clk) {store_to_scratch_bit, load_from_scratch_bit} <= 2'h0;
    if (s) m[63][6] = m[rg][p]; else m[rg][p] = m[63][6];
  endtask
  task automatic gp(input [3:0] v);
    @(posedge clk) {irq_gate_on, irq_gate_off, irq_taken, return_from_irq} <= v;
    @(posedge clk) {irq_gate_on, irq_gate_off, irq_taken, return_from_irq} <= 4'h0;
    m[63][7] = v[3] | v[0];
    @(negedge clk) `CHK("accept", m[63][7] & irq_request, irq_accept)
  endtask
  // Flags follow the reported result, enables pick carry, half and overflow
  task automatic alu(input integer k);
    @(posedge clk) begin
      {a, b} <= k == 0 ? 16'h8080 : 16'($random(seed));
      {sub, alu_half_en, alu_ovf_en, alu_carry_en} <= 4'($random(seed));
      alu_done <= 1;
    end
    @(posedge clk) alu_done <= 0;
    m[63][2:0] = {alu_result[7], alu_result == 8'h00, alu_carry_en ? alu_carry : m[63][0]};
    if (alu_half_en) m[63][5] = alu_half;
    if (alu_ovf_en) m[63][3] = alu_ovf;
    m[63][4] = m[63][2] ^ m[63][3];
    rreg(`STATUS_OFFSET);
  endtask
  initial begin
    for (i = 0; i < 64; i++) m[i] = 8'h00;
    repeat (2) @(posedge clk);
    srst <= 0;
    for (i = 0; i < 64; i++) rreg(6'(i));
    for (i = 0; i < 64; i++) begin
      wreg(6'(i), 8'($random(seed)));
      rreg(6'(i));
    end
    $display("map test done");
    for (i = 0; i < 16; i++) begin
      r = 5'($random(seed)) & ~{4'h0, i[0]};
      resw(i[0], r, 16'($random(seed)));
      bop(1'b1, 5'($random(seed)), 3'($random(seed)));
      bop(1'b0, r, 3'($random(seed)));
      @(posedge clk) {src_a_addr, src_b_addr} <= {r, 5'($random(seed))};
      @(negedge clk) `CHK("pair", {m[r | 5'h01], m[r]}, src_pair_data)
      `CHK("src", {m[r], m[src_b_addr]}, {src_a_data, src_b_data})
    end
    `CHK("ptr", {m[27], m[26], m[29], m[28], m[31], m[30]}, {ptr_x, ptr_y, ptr_z})
    for (i = 0; i < 64; i++) rreg(6'(i));
    $display("bank test done");
    for (i = 0; i < 24; i++) alu(i);
    $display("flag test done");
    foreach (gv[j]) gp(gv[j]);
    rreg(`STATUS_OFFSET);
    irq_request <= 0;
    gp(4'h8);
    $display("gate test done");
    results();
  end
endmodule // testbench
